// [verilog/alu_core.sv]
`timescale 1ns/1ps
module alu_core
  import alu_pkg::*;
(
  // Clock and reset
  input  wire logic     i_sys_clk,
  input  wire logic     i_reset,
  // Request from decoder
  input  wire logic     i_valid,
  input  alu_req_t      i_req,
  // Result and flags
  output alu_rsp_t      o_rsp,
  output alu_ccr_t      o_ccr
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    alu_rsp_t rsp;
    alu_ccr_t condition_code_register;
  } alu_state_t;

  alu_state_t st_r;
  alu_state_t st_nxt;

  logic [15:0] qb;
  logic [15:0] rb;
  logic [15:0] qw;
  logic [15:0] rw;
  logic [31:0] div_num_b;
  logic [15:0] div_den_b;
  logic [31:0] div_num_w;
  logic [15:0] div_den_w;

  // Byte division reuses the word divider with zero-extended operands.
  alu_divider #(.W(16)) u_div_b (
    .i_dividend (div_num_b),
    .i_divisor  (div_den_b),
    .o_quot     (qb),
    .o_rem      (rb)
  );
  alu_divider #(.W(16)) u_div_w (
    .i_dividend (div_num_w),
    .i_divisor  (div_den_w),
    .o_quot     (qw),
    .o_rem      (rw)
  );

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] szmask(input alu_size_t s);
    unique case (s)
      SZ_BYTE: szmask = 32'h0000_00FF;
      SZ_WORD: szmask = 32'h0000_FFFF;
      default: szmask = 32'hFFFF_FFFF;
    endcase
  endfunction : szmask

  function automatic int msb(input alu_size_t s);
    unique case (s)
      SZ_BYTE: msb = 7;
      SZ_WORD: msb = 15;
      default: msb = 31;
    endcase
  endfunction : msb

  logic [31:0] a;
  logic [31:0] b;
  logic [32:0] sum;
  logic [31:0] res;
  logic [31:0] mask;
  logic        sub;
  logic        wr;
  logic        ref_op;
  logic        cin;
  logic        cset;
  logic        vset;
  logic        logic_op;
  logic        keep_v;
  logic        sa;
  logic        sb;
  logic [15:0] ma;
  logic [15:0] mb;
  logic [7:0]  da;
  logic [7:0]  adj;
  logic        divneg;
  logic        remneg;
  logic [31:0] prod;
  int          m;
  int          n;
  alu_ccr_t    f;

  always_comb begin
    st_nxt = st_r;
    f = st_r.condition_code_register;
    mask = szmask(i_req.size);
    m = msb(i_req.size);
    a = i_req.dst & mask;
    b = (i_req.use_imm ? i_req.imm : i_req.src) & mask;
    sub = 1'b0;
    cin = 1'b0;
    wr = 1'b1;
    ref_op = 1'b0;
    logic_op = 1'b0;
    keep_v = 1'b0;
    res = '0;
    cset = f.c;
    vset = 1'b0;
    sum = '0;
    sa = 1'b0;
    sb = 1'b0;
    ma = '0;
    mb = '0;
    da = '0;
    adj = '0;
    divneg = 1'b0;
    remneg = 1'b0;
    prod = '0;
    n = 1;
    div_num_b = '0;
    div_den_b = '0;
    div_num_w = '0;
    div_den_w = '0;
    unique case (i_req.op)
      OP_ADD, OP_SUB, OP_CMP, OP_ADD_WITH_CARRY_OP, OP_SUBTRACT_WITH_CARRY_OP, OP_NEG: begin
        if (i_req.op == OP_NEG) begin
          b = a;
          a = '0;
        end
        sub = (i_req.op != OP_ADD) && (i_req.op != OP_ADD_WITH_CARRY_OP); // [RQ1] [RQ11]
        if (i_req.op == OP_ADD_WITH_CARRY_OP || i_req.op == OP_SUBTRACT_WITH_CARRY_OP) begin
          cin = st_r.condition_code_register.c; // [RQ2]
          ref_op = (i_req.size != SZ_BYTE); // [RQ2]
        end
        if (i_req.op == OP_SUB && i_req.use_imm && i_req.size == SZ_BYTE) begin
          ref_op = 1'b1; // [RQ1]
        end
        wr = (i_req.op != OP_CMP); // [RQ10]
        sum = sub ? ({1'b0, a} - {1'b0, b} - {32'h0, cin})
                  : ({1'b0, a} + {1'b0, b} + {32'h0, cin});
        res = sum[31:0] & mask;
        cset = sum[m + 1] ^ (|(a >> (m + 1))) ; // [RQ24]
        vset = sub ? (a[m] != b[m]) && (res[m] != a[m])
                   : (a[m] == b[m]) && (res[m] != a[m]); // [RQ24]
      end
      OP_INC, OP_DEC: begin
        n = (i_req.amount == 2'd2) ? 2 : 1; // [RQ3]
        b = 32'(n);
        sum = (i_req.op == OP_DEC) ? {1'b0, a} - {1'b0, b}
                                   : {1'b0, a} + {1'b0, b};
        res = sum[31:0] & mask; // [RQ3]
        cset = f.c;
        vset = (i_req.op == OP_DEC) ? (a[m] && !res[m]) : (!a[m] && res[m]);
      end
      OP_ADDS, OP_POINTER_SUBTRACT_OP: begin
        ref_op = (i_req.size != SZ_LONG); // [RQ4]
        n = (i_req.amount == 2'd3) ? 4 : ((i_req.amount == 2'd2) ? 2 : 1);
        res = (i_req.op == OP_POINTER_SUBTRACT_OP) ? i_req.dst - 32'(n)
                                    : i_req.dst + 32'(n); // [RQ4]
        mask = 32'hFFFF_FFFF;
        keep_v = 1'b1;
      end
      OP_DAA, OP_DAS: begin
        da = a[7:0];
        if (st_r.condition_code_register.c || da > 8'h99) adj[7:4] = 4'h6; // [RQ5]
        if (da[3:0] > 4'h9) adj[3:0] = 4'h6; // [RQ5]
        res = {24'h0, (i_req.op == OP_DAA) ? da + adj : da - adj};
        cset = (i_req.op == OP_DAA) ? (st_r.condition_code_register.c || da > 8'h99) : st_r.condition_code_register.c;
        ref_op = (i_req.size != SZ_BYTE);
      end
      OP_MULU, OP_MULS: begin
        ma = (i_req.size == SZ_BYTE) ? {8'h0, a[7:0]} : a[15:0];
        mb = (i_req.size == SZ_BYTE) ? {8'h0, i_req.src[7:0]} : i_req.src[15:0];
        if (i_req.op == OP_MULS) begin
          sa = ma[msb(i_req.size)];
          sb = mb[msb(i_req.size)];
          if (sa) ma = (i_req.size == SZ_BYTE) ? {8'h0, 8'(-ma[7:0])} : -ma;
          if (sb) mb = (i_req.size == SZ_BYTE) ? {8'h0, 8'(-mb[7:0])} : -mb;
        end
        prod = 32'(ma) * 32'(mb); // [RQ6]
        if (sa ^ sb) prod = -prod; // [RQ7]
        mask = (i_req.size == SZ_BYTE) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        res = prod & mask;
        ref_op = (i_req.size == SZ_LONG);
        keep_v = 1'b1;
      end
      OP_DIVU, OP_DIVS: begin
        mask = (i_req.size == SZ_BYTE) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        div_num_b = {16'h0, i_req.dst[15:0]};
        div_den_b = {8'h0, i_req.src[7:0]};
        div_num_w = i_req.dst;
        div_den_w = i_req.src[15:0];
        if (i_req.op == OP_DIVS) begin
          remneg = (i_req.size == SZ_BYTE) ? i_req.dst[15] : i_req.dst[31];
          divneg = remneg ^ ((i_req.size == SZ_BYTE) ? i_req.src[7]
                                                    : i_req.src[15]);
          if (i_req.dst[15]) div_num_b = {16'h0, 16'(-i_req.dst[15:0])};
          if (i_req.src[7]) div_den_b = {8'h0, 8'(-i_req.src[7:0])};
          if (i_req.dst[31]) div_num_w = -i_req.dst;
          if (i_req.src[15]) div_den_w = -i_req.src[15:0];
        end
        if (i_req.size == SZ_BYTE) begin // [RQ8] [RQ9]
          res = {16'h0, remneg ? 8'(-rb[7:0]) : rb[7:0],
                 divneg ? 8'(-qb[7:0]) : qb[7:0]};
        end else begin
          res = {remneg ? -rw : rw, divneg ? -qw : qw}; // [RQ8] [RQ9]
        end
        ref_op = (i_req.size == SZ_LONG);
        keep_v = 1'b1;
      end
      OP_ZERO_EXTEND_OP, OP_SIGN_EXTEND_OP: begin
        ref_op = (i_req.size == SZ_BYTE);
        if (i_req.size == SZ_WORD) begin
          res = {16'h0, (i_req.op == OP_SIGN_EXTEND_OP && a[7]) ? 8'hFF : 8'h00,
                 a[7:0]}; // [RQ12] [RQ13]
        end else begin
          res = {(i_req.op == OP_SIGN_EXTEND_OP && a[15]) ? 16'hFFFF : 16'h0000,
                 a[15:0]}; // [RQ12] [RQ13]
        end
        logic_op = 1'b1;
      end
      OP_TAS: begin
        res = {24'h0, a[7:0] | TAS_SET_MASK}; // [RQ14]
        mask = 32'h0000_00FF;
        logic_op = 1'b1;
        ref_op = (i_req.size != SZ_BYTE);
      end
      OP_AND, OP_OR, OP_XOR, OP_NOT: begin
        logic_op = 1'b1;
        unique case (i_req.op)
          OP_AND: res = a & b; // [RQ16]
          OP_OR: res = a | b; // [RQ16]
          OP_XOR: res = a ^ b; // [RQ16]
          default: res = ~a & mask; // [RQ17]
        endcase
      end
      default: begin
        // Shifts and rotates; two positions run the one-step loop twice.
        res = a;
        cset = f.c;
        n = (i_req.amount == 2'd2) ? 2 : 1;
        for (int k = 0; k < 2; k++) begin
          if (k < n) begin
            unique case (i_req.op)
              OP_ARITH_SHIFT_LEFT, OP_LOGIC_SHIFT_LEFT: begin
                cset = res[m]; // [RQ18] [RQ19]
                vset = vset | (res[m] ^ res[m - 1]);
                res = (res << 1) & mask;
              end
              OP_ARITH_SHIFT_RIGHT: begin
                cset = res[0];
                res = (res >> 1) | (32'(res[m]) << m); // [RQ18]
              end
              OP_LOGIC_SHIFT_RIGHT: begin
                cset = res[0];
                res = res >> 1; // [RQ19]
              end
              OP_ROTATE_LEFT: begin
                cset = res[m];
                res = ((res << 1) | 32'(res[m])) & mask; // [RQ20]
              end
              OP_ROTATE_RIGHT: begin
                cset = res[0];
                res = (res >> 1) | (32'(res[0]) << m); // [RQ20]
              end
              OP_ROTATE_LEFT_VIA_CARRY: begin
                sa = res[m];
                res = ((res << 1) | 32'(cset)) & mask; // [RQ21]
                cset = sa;
              end
              default: begin
                sa = res[0];
                res = (res >> 1) | (32'(cset) << m); // [RQ21]
                cset = sa;
              end
            endcase
          end
        end
        if (i_req.op != OP_ARITH_SHIFT_LEFT) vset = 1'b0;
      end
    endcase
    if (i_req.op == OP_TAS) wr = 1'b1;
    if (i_valid && !ref_op) begin
      if (!keep_v && i_req.op != OP_ADDS && i_req.op != OP_POINTER_SUBTRACT_OP) begin
        f.n = (i_req.op == OP_TAS) ? a[7] : res[m]; // [RQ22]
        f.z = (i_req.op == OP_TAS) ? (a[7:0] == 8'h00)
                                   : ((res & mask) == 32'h0); // [RQ22]
        f.v = logic_op ? 1'b0 : vset; // [RQ24]
        if (!logic_op) f.c = cset; // [RQ24]
      end
      if ((i_req.op == OP_INC || i_req.op == OP_DEC)) f.c = st_r.condition_code_register.c;
      st_nxt.condition_code_register = f;
    end
    st_nxt.rsp.valid = i_valid;
    st_nxt.rsp.refused = i_valid && ref_op;
    st_nxt.rsp.write = i_valid && !ref_op && wr;
    // Bits outside the result mask keep the destination's old contents.
    st_nxt.rsp.result = (i_req.dst & ~mask) | (res & mask); // [RQ23]
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_r.rsp <= '{valid: 1'b0, write: 1'b0, refused: 1'b0,
                    result: RESULT_RESET, condition_code_register: CCR_RESET};
      st_r.condition_code_register <= CCR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    o_rsp = st_r.rsp;
    o_rsp.condition_code_register = st_r.condition_code_register;
  end
  assign o_ccr = st_r.condition_code_register;

  //////////////////////////////////////////////////////////////////////////////
  a_cmp_no_write: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_valid && i_req.op == OP_CMP |=> !o_rsp.write) // [RQ10]
    else $error("compare wrote its destination");

  a_byte_sub_imm: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_valid && i_req.op == OP_SUB && i_req.use_imm && i_req.size == SZ_BYTE
    |=> o_rsp.refused && !o_rsp.write) // [RQ1]
    else $error("byte immediate subtract was not refused");

  a_add_byte_sum: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_valid && i_req.op == OP_ADD && i_req.size == SZ_BYTE && !i_req.use_imm
    |=> o_rsp.result[7:0] == 8'($past(i_req.dst[7:0]) + $past(i_req.src[7:0]))
        && o_rsp.result[31:8] == $past(i_req.dst[31:8])) // [RQ1]
    else $error("byte add result wrong");

  a_neg_value: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_valid && i_req.op == OP_NEG && i_req.size == SZ_LONG
    |=> o_rsp.result == -$past(i_req.dst)) // [RQ11]
    else $error("negate result wrong");

  a_tas_bit7: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_valid && i_req.op == OP_TAS && i_req.size == SZ_BYTE
    |=> o_rsp.result[7] && o_rsp.condition_code_register.z == ($past(i_req.dst[7:0]) == 8'h00))
    // [RQ14]
    else $error("test-and-set wrong");

  a_logic_clr_v: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_valid && i_req.op inside {OP_AND, OP_OR, OP_XOR, OP_NOT}
    |=> !o_ccr.v) // [RQ24]
    else $error("logic op left overflow set");

  a_adds_long: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_valid && i_req.op == OP_ADDS && i_req.size == SZ_LONG
    && i_req.amount == 2'd3 |=> o_rsp.result == $past(i_req.dst) + 32'h4)
    // [RQ4]
    else $error("pointer add by four wrong");

  a_mulu_byte: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_valid && i_req.op == OP_MULU && i_req.size == SZ_BYTE
    |=> o_rsp.result[15:0] == 16'($past(i_req.dst[7:0]))
        * 16'($past(i_req.src[7:0])))
    // [RQ6]
    else $error("unsigned byte multiply wrong");

  a_logic_shift_right_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    i_valid && i_req.op == OP_LOGIC_SHIFT_RIGHT && i_req.size == SZ_BYTE
    && i_req.amount == 2'd2 |=> o_rsp.result[7:6] == 2'b00) // [RQ19]
    else $error("logical right shift did not fill zeros");

endmodule : alu_core

// [verilog/alu_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// (RQ1) Add/subtract destination with register or immediate; no byte immediate subtract.
// (RQ2) Add/subtract with carry work on bytes only, including the carry flag.
// (RQ3) Increment or decrement a register by 1 or 2, any size.
// (RQ4) Pointer add or subtract 1, 2 or 4 on a longword register.
// (RQ5) Decimal adjust a byte after add or subtract using flags.
// (RQ6) Unsigned multiply 8x8 to 16 bits, or 16x16 to 32 bits.
// (RQ7) Signed multiply with the same widths as unsigned multiply.
// (RQ8) Unsigned divide 16/8 or 32/16 giving quotient and remainder.
// (RQ9) Signed divide 16/8 or 32/16 giving quotient and remainder.
// (RQ10) Compare subtracts, updates flags only, keeps destination.
// (RQ11) Negate replaces register with zero minus its value.
// (RQ12) Zero extend clears the upper half above the lower half.
// (RQ13) Sign extend copies lower half top bit into upper half.
// (RQ14) Test-and-set flags a byte against zero and writes bit 7 set.
// (RQ15) Software should use pointer registers 0, 1, 4 or 5 for test-and-set.
// (RQ16) AND, OR, XOR combine destination with register or immediate.
// (RQ17) Complement inverts every bit of the selected size.
// (RQ18) Arithmetic shifts by 1 or 2; right shift keeps the sign bit.
// (RQ19) Logical shifts by 1 or 2 fill with zeros.
// (RQ20) Rotates by 1 or 2 re-enter bits at the other end.
// (RQ21) Rotates through carry include the carry as an extra bit.
// (RQ22) Condition codes hold negative, zero, overflow and carry flags.
// (RQ23) All but compare write back, only the sized bits.
// (RQ24) Usual two's complement carry/overflow; logic clears overflow.
//////////////////////////////////////////////////////////////////////////////
package alu_pkg;

  typedef enum logic [5:0] {
    OP_ADD, OP_SUB, OP_ADD_WITH_CARRY_OP, OP_SUBTRACT_WITH_CARRY_OP, OP_INC, OP_DEC, OP_ADDS, OP_POINTER_SUBTRACT_OP,
    OP_DAA, OP_DAS, OP_MULU, OP_MULS, OP_DIVU, OP_DIVS, OP_CMP, OP_NEG,
    OP_ZERO_EXTEND_OP, OP_SIGN_EXTEND_OP, OP_TAS, OP_AND, OP_OR, OP_XOR, OP_NOT,
    OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ROTATE_LEFT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY
  } alu_op_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} alu_size_t;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } alu_ccr_t;

  typedef struct packed {
    alu_op_t   op;
    alu_size_t size;
    logic      use_imm;
    logic [1:0] amount;
    logic [31:0] dst;
    logic [31:0] src;
    logic [31:0] imm;
  } alu_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        refused;
    logic [31:0] result;
    alu_ccr_t    condition_code_register;
  } alu_rsp_t;

  localparam alu_ccr_t CCR_RESET = '0;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [7:0] TAS_SET_MASK = 8'h80;
  localparam int DIV_STEPS_BYTE = 8;
  localparam int DIV_STEPS_WORD = 16;

endpackage : alu_pkg

// [verilog/alu_divider.sv]
`timescale 1ns/1ps
// Single-cycle restoring divider on magnitudes; signs are fixed by caller.
module alu_divider
  import alu_pkg::*;
#(
  parameter int W = 16
) (
  // Operands
  input  wire logic [2*W-1:0] i_dividend,
  input  wire logic [W-1:0]   i_divisor,
  // Results
  output logic      [W-1:0]   o_quot,
  output logic      [W-1:0]   o_rem
);
  logic [W:0]   rem;
  logic [W-1:0] q;
  always_comb begin
    rem = '0;
    q = '0;
    for (int i = 2*W-1; i >= 0; i--) begin
      rem = {rem[W-1:0], i_dividend[i]};
      if (rem >= {1'b0, i_divisor}) begin
        rem = rem - {1'b0, i_divisor};
        if (i < W) q[i] = 1'b1;
      end
    end
    o_quot = q;
    o_rem = rem[W-1:0];
  end
endmodule : alu_divider

// [tb/alu_decoder_model.sv]
`timescale 1ns/1ps
module alu_decoder_model
  import alu_pkg::*;
(
  // Clock and returned result
  input  wire logic i_sys_clk,
  input  alu_rsp_t  i_rsp,
  // Request to the unit
  output logic      o_valid,
  output alu_req_t  o_req
);
  logic [31:0] regs [8];
  logic [2:0]  cur_idx;
  logic [2:0]  pend_idx;

  initial begin
    o_valid = 1'h0;
    o_req = '0;
    cur_idx = 3'h0;
    pend_idx = 3'h0;
    foreach (regs[k]) regs[k] = 32'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  // The index is kept one cycle so back-to-back ops land in their own reg.
  always @(posedge i_sys_clk) begin
    if (i_rsp.valid && i_rsp.write) begin
      regs[pend_idx] <= i_rsp.result;
    end
    if (o_valid) begin
      pend_idx <= cur_idx;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic issue(input alu_op_t op, input alu_size_t sz,
                       input logic ui, input logic [1:0] amt,
                       input logic [2:0] idx, input logic [31:0] src,
                       input logic [31:0] imm);
    o_valid = 1'h1;
    cur_idx = idx;
    o_req = '{op, sz, ui, amt, regs[idx], src, imm};
    @(negedge i_sys_clk);
  endtask : issue

  // Released operands show the inverse, so a late read cannot pass by luck.
  task automatic drop_req();
    o_valid = 1'h0;
    o_req.dst = ~o_req.dst;
    o_req.src = ~o_req.src;
    o_req.imm = ~o_req.imm;
  endtask : drop_req
endmodule : alu_decoder_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import alu_pkg::*;

  localparam logic [1:0] WR = 2'h0;
  localparam logic [1:0] NW = 2'h1;
  localparam logic [1:0] RF = 2'h2;

  logic     i_sys_clk;
  logic     i_reset;
  logic     req_valid;
  alu_req_t req;
  alu_rsp_t rsp;
  alu_ccr_t condition_code_register;
  int       fail_count;
  int       samples_checked;

  initial begin
    i_sys_clk = 1'h0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  alu_decoder_model model (.i_sys_clk(i_sys_clk), .i_rsp(rsp),
                           .o_valid(req_valid), .o_req(req));
  alu_core dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
                .i_valid(req_valid), .i_req(req), .o_rsp(rsp), .o_ccr(condition_code_register));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic see_rsp(input logic [1:0] k, input logic [31:0] res,
                         input logic [3:0] cc, input logic [3:0] m);
    chk({31'h0, rsp.valid}, 32'h1);
    chk({30'h0, rsp.write, rsp.refused}, {30'h0, k == WR, k == RF});
    if (k != RF) chk(rsp.result, res);
    chk({28'h0, condition_code_register & m}, {28'h0, cc & m});
  endtask : see_rsp

  task automatic run(input alu_op_t op, input alu_size_t sz, input logic ui,
                     input logic [1:0] amt, input logic [31:0] dst,
                     input logic [31:0] src, input logic [31:0] res,
                     input logic [3:0] cc, input logic [3:0] m,
                     input logic [1:0] k);
    model.regs[1] = dst;
    model.issue(op, sz, ui, amt, 3'h1, src, src);
    model.drop_req();
    see_rsp(k, res, cc, m);
    @(negedge i_sys_clk);
    chk(model.regs[1], (k == WR) ? res : dst);
  endtask : run

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state();
    chk(rsp.result, 32'h0);
    chk({21'h0, rsp.valid, rsp.write, rsp.refused, rsp.condition_code_register, condition_code_register},
        32'h0);
  endtask : t_reset_state

  task automatic t_arith();
    run(OP_ADD, SZ_BYTE, 1'h0, 2'h1, 32'hAABBCC7F, 32'h1, 32'hAABBCC80,
        4'hA, 4'hF, WR);
    run(OP_SUB, SZ_WORD, 1'h0, 2'h1, 32'h12340000, 32'h1, 32'h1234FFFF,
        4'h9, 4'hF, WR);
    run(OP_ADD, SZ_LONG, 1'h1, 2'h1, 32'hFFFFFFFF, 32'h1, 32'h0,
        4'h5, 4'hF, WR);
    run(OP_SUB, SZ_BYTE, 1'h1, 2'h1, 32'h55, 32'h1, 32'h0,
        4'h5, 4'hF, RF);
    run(OP_ADD_WITH_CARRY_OP, SZ_BYTE, 1'h0, 2'h1, 32'h10, 32'h20, 32'h31,
        4'h0, 4'hF, WR);
    run(OP_SUBTRACT_WITH_CARRY_OP, SZ_BYTE, 1'h0, 2'h1, 32'h30, 32'h31, 32'hFF,
        4'h9, 4'hF, WR);
    run(OP_SUBTRACT_WITH_CARRY_OP, SZ_WORD, 1'h0, 2'h1, 32'h30, 32'h1, 32'h0,
        4'h9, 4'hF, RF);
    run(OP_INC, SZ_BYTE, 1'h0, 2'h1, 32'h7F, 32'h0, 32'h80,
        4'hB, 4'hF, WR);
    run(OP_DEC, SZ_WORD, 1'h0, 2'h2, 32'h1, 32'h0, 32'hFFFF,
        4'h9, 4'hF, WR);
    run(OP_ADDS, SZ_LONG, 1'h0, 2'h3, 32'hFFFFFFFE, 32'h0, 32'h2,
        4'h9, 4'hF, WR);
    run(OP_POINTER_SUBTRACT_OP, SZ_LONG, 1'h0, 2'h2, 32'h1, 32'h0, 32'hFFFFFFFF,
        4'h9, 4'hF, WR);
    run(OP_POINTER_SUBTRACT_OP, SZ_BYTE, 1'h0, 2'h1, 32'h1, 32'h0, 32'h0,
        4'h9, 4'hF, RF);
    run(OP_CMP, SZ_BYTE, 1'h0, 2'h1, 32'h5, 32'h5, 32'h0,
        4'h4, 4'hF, NW);
    run(OP_DAS, SZ_BYTE, 1'h0, 2'h1, 32'h0F, 32'h0, 32'h09,
        4'h0, 4'h0, WR);
    run(OP_DAA, SZ_BYTE, 1'h0, 2'h1, 32'h0A, 32'h0, 32'h10,
        4'h0, 4'h0, WR);
  endtask : t_arith

  task automatic t_muldiv();
    run(OP_MULU, SZ_BYTE, 1'h0, 2'h1, 32'hAAAA00FF, 32'hFF, 32'hAAAAFE01,
        4'h0, 4'h0, WR);
    run(OP_MULU, SZ_WORD, 1'h0, 2'h1, 32'hFFFF, 32'hFFFF, 32'hFFFE0001,
        4'h0, 4'h0, WR);
    run(OP_MULU, SZ_LONG, 1'h0, 2'h1, 32'h2, 32'h2, 32'h0,
        4'h0, 4'h0, RF);
    run(OP_MULS, SZ_BYTE, 1'h0, 2'h1, 32'hFF, 32'h2, 32'hFFFE,
        4'h0, 4'h0, WR);
    run(OP_MULS, SZ_WORD, 1'h0, 2'h1, 32'h8000, 32'h2, 32'hFFFF0000,
        4'h0, 4'h0, WR);
    run(OP_DIVU, SZ_BYTE, 1'h0, 2'h1, 32'h0064, 32'h7, 32'h020E,
        4'h0, 4'h0, WR);
    run(OP_DIVU, SZ_WORD, 1'h0, 2'h1, 32'h10000, 32'h2, 32'h8000,
        4'h0, 4'h0, WR);
    run(OP_DIVS, SZ_BYTE, 1'h0, 2'h1, 32'h1234FF9C, 32'h7, 32'h1234FEF2,
        4'h0, 4'h0, WR);
    run(OP_DIVS, SZ_WORD, 1'h0, 2'h1, 32'hFFFFFF9C, 32'h7, 32'hFFFEFFF2,
        4'h0, 4'h0, WR);
  endtask : t_muldiv

  task automatic t_unary();
    run(OP_NEG, SZ_BYTE, 1'h0, 2'h1, 32'h1, 32'h0, 32'hFF,
        4'h9, 4'hF, WR);
    run(OP_NEG, SZ_WORD, 1'h0, 2'h1, 32'h8000, 32'h0, 32'h8000,
        4'hB, 4'hF, WR);
    run(OP_NEG, SZ_LONG, 1'h0, 2'h1, 32'h1, 32'h0, 32'hFFFFFFFF,
        4'h9, 4'hF, WR);
    run(OP_ZERO_EXTEND_OP, SZ_WORD, 1'h0, 2'h1, 32'h1234ABCD, 32'h0, 32'h123400CD,
        4'h0, 4'h0, WR);
    run(OP_ZERO_EXTEND_OP, SZ_LONG, 1'h0, 2'h1, 32'hFFFF1234, 32'h0, 32'h1234,
        4'h0, 4'h0, WR);
    run(OP_SIGN_EXTEND_OP, SZ_WORD, 1'h0, 2'h1, 32'hF0, 32'h0, 32'hFFF0,
        4'h0, 4'h0, WR);
    run(OP_SIGN_EXTEND_OP, SZ_LONG, 1'h0, 2'h1, 32'h8001, 32'h0, 32'hFFFF8001,
        4'h0, 4'h0, WR);
    run(OP_SIGN_EXTEND_OP, SZ_BYTE, 1'h0, 2'h1, 32'h81, 32'h0, 32'h0,
        4'h0, 4'h0, RF);
    // Pointer index 1 is one of the allowed set.
    run(OP_TAS, SZ_BYTE, 1'h0, 2'h1, 32'h0, 32'h0, 32'h80,
        4'h4, 4'hE, WR);
    run(OP_AND, SZ_WORD, 1'h1, 2'h1, 32'hFFFFF0F0, 32'h0FF0, 32'hFFFF00F0,
        4'h0, 4'hE, WR);
    run(OP_OR, SZ_BYTE, 1'h0, 2'h1, 32'h0, 32'h80, 32'h80,
        4'h8, 4'hE, WR);
    run(OP_XOR, SZ_LONG, 1'h1, 2'h1, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0,
        4'h4, 4'hE, WR);
    run(OP_NOT, SZ_WORD, 1'h0, 2'h1, 32'h12340000, 32'h0, 32'h1234FFFF,
        4'h8, 4'hE, WR);
  endtask : t_unary

  task automatic t_shift();
    logic [31:0] d;
    d = 32'h5A5A5A81;
    run(OP_ARITH_SHIFT_LEFT, SZ_BYTE, 1'h0, 2'h1, d, 32'h0, 32'h5A5A5A02,
        4'h3, 4'hD, WR);
    run(OP_ARITH_SHIFT_RIGHT, SZ_BYTE, 1'h0, 2'h1, d, 32'h0, 32'h5A5A5AC0,
        4'h9, 4'hD, WR);
    run(OP_LOGIC_SHIFT_LEFT, SZ_BYTE, 1'h0, 2'h2, d, 32'h0, 32'h5A5A5A04,
        4'h0, 4'hD, WR);
    run(OP_LOGIC_SHIFT_RIGHT, SZ_BYTE, 1'h0, 2'h1, d, 32'h0, 32'h5A5A5A40,
        4'h1, 4'hD, WR);
    run(OP_LOGIC_SHIFT_RIGHT, SZ_BYTE, 1'h0, 2'h2, d, 32'h0, 32'h5A5A5A20,
        4'h0, 4'hD, WR);
    run(OP_ROTATE_LEFT, SZ_BYTE, 1'h0, 2'h1, d, 32'h0, 32'h5A5A5A03,
        4'h1, 4'hD, WR);
    run(OP_ROTATE_RIGHT, SZ_BYTE, 1'h0, 2'h1, d, 32'h0, 32'h5A5A5AC0,
        4'h9, 4'hD, WR);
    run(OP_ROTATE_LEFT_VIA_CARRY, SZ_BYTE, 1'h0, 2'h1, 32'h5A5A5A01, 32'h0, 32'h5A5A5A03,
        4'h0, 4'hD, WR);
    run(OP_ROTATE_RIGHT_VIA_CARRY, SZ_BYTE, 1'h0, 2'h2, d, 32'h0, 32'h5A5A5AA0,
        4'h8, 4'hD, WR);
    run(OP_ARITH_SHIFT_RIGHT, SZ_WORD, 1'h0, 2'h2, 32'h8000, 32'h0, 32'hE000,
        4'h8, 4'hD, WR);
  endtask : t_shift

  // Two ops in adjacent cycles; each result must reach its own register.
  task automatic t_back_to_back();
    model.regs[2] = 32'h1;
    model.regs[3] = 32'h10;
    model.issue(OP_ADD, SZ_BYTE, 1'h0, 2'h1, 3'h2, 32'h2, 32'h0);
    see_rsp(WR, 32'h3, 4'h0, 4'hF);
    model.issue(OP_SUB, SZ_BYTE, 1'h0, 2'h1, 3'h3, 32'h10, 32'h0);
    model.drop_req();
    see_rsp(WR, 32'h0, 4'h4, 4'hF);
    @(negedge i_sys_clk);
    chk(model.regs[2], 32'h3);
    chk(model.regs[3], 32'h0);
  endtask : t_back_to_back

  //////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  initial begin
    fail_count = 0;
    samples_checked = 0;
    i_reset = 1'h1;
    repeat (2) @(negedge i_sys_clk);
    i_reset = 1'h0;
    t_reset_state();
    t_arith();
    t_muldiv();
    t_unary();
    t_shift();
    t_back_to_back();
    i_reset = 1'h1;
    repeat (2) @(negedge i_sys_clk);
    t_reset_state();
    i_reset = 1'h0;
    @(negedge i_sys_clk);
    test_done();
  end
endmodule : tb_top
